// [core/gss_pkg.sv]
package gss_pkg;

	// Data widths
	localparam int GSS_DW         = 32;
	localparam int GSS_GW         = 16;
	localparam int GSS_NUM_GAINS  = 7;
	localparam int GSS_NUM_SETS   = 2;

	// Clock and time base of the wait and ramp timers
	localparam int GSS_CLK_NS     = 10;
	localparam int GSS_TICK_NS    = 1000000;
	localparam int GSS_TICK_CYC   = GSS_TICK_NS / GSS_CLK_NS;

	// Member order inside one gain set
	localparam int GSS_G_SPEED    = 0;
	localparam int GSS_G_INTEG    = 1;
	localparam int GSS_G_POS      = 2;
	localparam int GSS_G_TRQF     = 3;
	localparam int GSS_G_MFGAIN   = 4;
	localparam int GSS_G_MFCOMP   = 5;
	localparam int GSS_G_FRIC     = 6;

	// Register byte offsets
	localparam logic [7:0] GSS_OFS_SET_A   = 8'h00;
	localparam logic [7:0] GSS_OFS_SET_B   = 8'h40;
	localparam logic [7:0] GSS_OFS_CFG     = 8'h80;
	localparam logic [7:0] GSS_OFS_WAIT1   = 8'h84;
	localparam logic [7:0] GSS_OFS_WAIT2   = 8'h88;
	localparam logic [7:0] GSS_OFS_RAMP1   = 8'h8c;
	localparam logic [7:0] GSS_OFS_RAMP2   = 8'h90;
	localparam logic [7:0] GSS_OFS_CTRL    = 8'h94;
	localparam logic [7:0] GSS_OFS_STATUS  = 8'h98;

	// Switching configuration fields
	localparam int GSS_METH_LSB   = 0;
	localparam int GSS_COND_LSB   = 4;
	localparam logic [3:0] GSS_METH_MANUAL = 4'h0;
	localparam logic [3:0] GSS_METH_AUTO   = 4'h2;

	// Condition A selections
	localparam logic [3:0] GSS_CA_POSITIONING_COMPLETE_FLAG_ON  = 4'h0;
	localparam logic [3:0] GSS_CA_POSITIONING_COMPLETE_FLAG_OFF = 4'h1;
	localparam logic [3:0] GSS_CA_NEAR_ON  = 4'h2;
	localparam logic [3:0] GSS_CA_NEAR_OFF = 4'h3;
	localparam logic [3:0] GSS_CA_REF_IDLE = 4'h4;
	localparam logic [3:0] GSS_CA_REF_ON   = 4'h5;

	// Reset values
	localparam logic [15:0] GSS_RST_CFG  = 16'h0000;
	localparam logic [15:0] GSS_RST_TIME = 16'h0000;
	localparam logic [15:0] GSS_RST_CTRL = 16'h0000;
	localparam logic [GSS_NUM_GAINS-1:0][GSS_GW-1:0] GSS_RST_GAINS = {
		16'h0064, 16'h03e8, 16'h01f4, 16'h0064,
		16'h0190, 16'h07d0, 16'h0190};

	// Switcher sequencing states
	typedef enum logic [1:0] {
		GSS_ST_IDLE,
		GSS_ST_WAIT,
		GSS_ST_RAMP
	} gss_state_t;

	// Whole state of the switcher
	typedef struct packed {
		logic [GSS_NUM_SETS-1:0][GSS_NUM_GAINS-1:0][GSS_GW-1:0] gain;
		logic [15:0]                    cfg;
		logic [1:0][15:0]               wait_t;
		logic [1:0][15:0]               ramp_t;
		logic [15:0]                    ctrl;
		gss_state_t                     st;
		logic [31:0]                    tick_cnt;
		logic [15:0]                    cnt;
		logic                           cur;
		logic                           dst;
		logic                           mf;
		logic [GSS_DW-1:0]              prdata;
		logic [GSS_NUM_GAINS-1:0][GSS_GW-1:0] out;
	} gss_regs_t;

endpackage

// [core/gss_ramp.sv]
`timescale 1ns/100ps
`default_nettype none

// Linear blend between two gain values
module gss_ramp
	import gss_pkg::*;
#(
	parameter int W = 16
) (
	// Endpoints
	input  wire logic [W-1:0]  i_from,
	input  wire logic [W-1:0]  i_to,
	// Progress: step out of span
	input  wire logic [15:0]   i_step,
	input  wire logic [15:0]   i_span,
	// Blended value
	output logic [W-1:0]       o_value
);

	logic signed [W:0]    diff;   // Signed distance to travel
	logic signed [W+17:0] prod;   // Distance scaled by progress
	logic signed [W+17:0] quot;   // Part of distance covered

	// Zero span or finished ramp lands on the target directly
	always_comb begin
		diff = $signed({1'b0, i_to}) - $signed({1'b0, i_from});
		prod = diff * $signed({2'b00, i_step});
		quot = '0;
		o_value = i_to;
		if (i_span != '0 && i_step < i_span) begin
			// Truncation toward zero keeps value between endpoints
			quot = prod / $signed({2'b00, i_span});
			o_value = W'(quot + $signed({1'b0, i_from}));
		end
	end

endmodule

`default_nettype wire

// [core/gss_switcher.sv]
// Functional notes
// - Config low digit: 0 manual, 2 automatic.
// - Two seven-member sets swap together.
// - Model-following pair swaps manual, idle, stopped.
// - Manual: select off set1, on set2.
// - Automatic switching only in position control.
// - A true: 1to2 with times 1.
// - Second digit picks condition A source.
// - Non-position: even selections set1, odd set2.
// - Wait programmed time before changing gains.
// - Gains ramp linearly within switching time.
// - Works under PI and I-P structures.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module gss_switcher
	import gss_pkg::*;
#(
	parameter int TICK_CYCLES = GSS_TICK_CYC
) (
	// Clock and reset
	input  wire logic                 i_mclk,
	input  wire logic                 i_rst,
	// APB slave
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic [7:0]           i_paddr,
	input  wire logic [GSS_DW-1:0]    i_pwdata,
	output logic                      o_pready,
	output logic                      o_pslverr,
	output logic [GSS_DW-1:0]         o_prdata,
	// Drive status inputs
	input  wire logic                 i_gain_select,
	input  wire logic                 i_pos_mode,
	input  wire logic                 i_cmd_busy,
	input  wire logic                 i_motor_stopped,
	input  wire logic                 i_positioning_complete_flag,
	input  wire logic                 i_near_flag,
	input  wire logic                 i_ref_filter_busy,
	input  wire logic                 i_ref_pulse,
	// Active gain values
	output logic [GSS_GW-1:0]         o_speed_gain,
	output logic [GSS_GW-1:0]         o_speed_integral,
	output logic [GSS_GW-1:0]         o_position_gain,
	output logic [GSS_GW-1:0]         o_torque_filter,
	output logic [GSS_GW-1:0]         o_model_follow_gain,
	output logic [GSS_GW-1:0]         o_model_follow_comp,
	output logic [GSS_GW-1:0]         o_friction_gain,
	// Switcher status
	output logic                      o_active_set,
	output logic                      o_switching,
	output logic [15:0]               o_control_structure_select
);

	gss_regs_t r_q;           // Registered state
	gss_regs_t r_d;           // Next state

	logic [3:0] meth;         // Switching method digit
	logic [3:0] csel;         // Condition A selection digit
	logic       is_auto;      // Automatic mode chosen
	logic       cond_a;       // Condition A currently true
	logic       fixed_set;    // Set used outside position control
	logic       want;         // Set the inputs ask for now
	logic       mf_ok;        // Model-following pair may swap
	logic       tick;         // One-cycle time base pulse
	logic       setup;        // APB setup phase
	logic       wr_en;        // APB write takes effect
	logic       hit;          // Address is mapped
	logic [15:0] span;        // Ramp length of current move
	logic [15:0] step;        // Ramp progress of current move
	logic [GSS_NUM_GAINS-1:0][GSS_GW-1:0] blend; // Ramp outputs
	logic [GSS_NUM_GAINS-1:0][GSS_GW-1:0] from_v; // Ramp starts
	logic [GSS_NUM_GAINS-1:0][GSS_GW-1:0] to_v;   // Ramp targets

	// Mode decode
	always_comb begin
		meth = r_q.cfg[GSS_METH_LSB +: 4];
		csel = r_q.cfg[GSS_COND_LSB +: 4];
		// Software never writes code 1; if it does, stay safe
		// Reserved code 1 falls back to manual
		is_auto = (meth == GSS_METH_AUTO);
	end

	// Condition A source select
	always_comb begin
		case (csel)
			GSS_CA_POSITIONING_COMPLETE_FLAG_ON:  cond_a = i_positioning_complete_flag;
			GSS_CA_POSITIONING_COMPLETE_FLAG_OFF: cond_a = !i_positioning_complete_flag;
			GSS_CA_NEAR_ON:  cond_a = i_near_flag;
			GSS_CA_NEAR_OFF: cond_a = !i_near_flag;
			GSS_CA_REF_IDLE: cond_a = !i_ref_filter_busy && !i_ref_pulse;
			GSS_CA_REF_ON:   cond_a = i_ref_pulse;
			default:         cond_a = i_positioning_complete_flag;
		endcase
	end

	// Fixed set outside position control
	always_comb begin
		case (csel)
			GSS_CA_POSITIONING_COMPLETE_FLAG_OFF,
			GSS_CA_NEAR_OFF,
			GSS_CA_REF_ON:   fixed_set = 1'b1;
			default:         fixed_set = 1'b0;
		endcase
	end

	// Desired set from mode and inputs
	always_comb begin
		if (!is_auto) begin
			want = i_gain_select;
		end else if (i_pos_mode) begin
			want = cond_a;
		end else begin
			want = fixed_set;
		end
		// Control structure is not consulted: both PI and I-P switch
		mf_ok = !is_auto && !i_cmd_busy && i_motor_stopped;
	end

	// Time base divider for wait and ramp counters
	// Tick phase is free, so a timed step may end up to one tick short
	always_comb begin
		tick = (r_q.tick_cnt == 32'(TICK_CYCLES - 1));
	end

	// Ramp progress: idle means already at target
	// Move to set 2 uses the first time pair, the return the second
	always_comb begin
		span = '0;
		step = '0;
		if (r_q.st == GSS_ST_RAMP) begin
			span = r_q.ramp_t[r_q.dst ? 0 : 1];
			step = r_q.cnt;
		end
	end

	// Endpoints for each member of the set
	always_comb begin
		for (int g = 0; g < GSS_NUM_GAINS; g++) begin
			from_v[g] = r_q.gain[r_q.cur][g];
			to_v[g]   = r_q.gain[r_q.dst][g];
			// Pair held on its own set, never ramped
			if (g == GSS_G_MFGAIN || g == GSS_G_MFCOMP) begin
				from_v[g] = r_q.gain[r_q.mf][g];
				to_v[g]   = r_q.gain[r_q.mf][g];
			end
		end
	end

	// One linear blender per member, all fed the same progress
	genvar gi;
	generate
		for (gi = 0; gi < GSS_NUM_GAINS; gi++) begin : g_ramp
			gss_ramp #(
				.W       (GSS_GW)
			) u_ramp (
				.i_from  (from_v[gi]),
				.i_to    (to_v[gi]),
				.i_step  (step),
				.i_span  (span),
				.o_value (blend[gi])
			);
		end
	endgenerate

	// APB decode
	// Only whole aligned words inside the mapped windows answer
	always_comb begin
		setup = i_psel && !i_penable;
		wr_en = i_psel && i_penable && i_pwrite;
		hit = (i_paddr[1:0] == 2'b00) && (
			(i_paddr < (GSS_OFS_SET_A + 8'(4 * GSS_NUM_GAINS))) ||
			((i_paddr >= GSS_OFS_SET_B) &&
			 (i_paddr < (GSS_OFS_SET_B + 8'(4 * GSS_NUM_GAINS)))) ||
			((i_paddr >= GSS_OFS_CFG) && (i_paddr <= GSS_OFS_STATUS)));
	end

	// Next-state logic
	always_comb begin
		r_d = r_q;

		// Free-running time base
		if (tick) begin
			r_d.tick_cnt = '0;
		end else begin
			r_d.tick_cnt = r_q.tick_cnt + 32'h0000_0001;
		end

		// Register writes land at the end of the access phase
		// Times are read live, so a rewrite mid-move takes effect at once
		if (wr_en && hit) begin
			for (int g = 0; g < GSS_NUM_GAINS; g++) begin
				if (i_paddr == GSS_OFS_SET_A + 8'(4 * g)) begin
					r_d.gain[0][g] = i_pwdata[GSS_GW-1:0];
				end
				if (i_paddr == GSS_OFS_SET_B + 8'(4 * g)) begin
					r_d.gain[1][g] = i_pwdata[GSS_GW-1:0];
				end
			end
			case (i_paddr)
				GSS_OFS_CFG:   r_d.cfg = i_pwdata[15:0];
				GSS_OFS_WAIT1: r_d.wait_t[0] = i_pwdata[15:0];
				GSS_OFS_WAIT2: r_d.wait_t[1] = i_pwdata[15:0];
				GSS_OFS_RAMP1: r_d.ramp_t[0] = i_pwdata[15:0];
				GSS_OFS_RAMP2: r_d.ramp_t[1] = i_pwdata[15:0];
				GSS_OFS_CTRL:  r_d.ctrl = i_pwdata[15:0];
				default: begin
					// Status is read-only
				end
			endcase
		end

		// Read data captured in setup, valid in access phase
		if (setup) begin
			r_d.prdata = '0;
			for (int g = 0; g < GSS_NUM_GAINS; g++) begin
				if (i_paddr == GSS_OFS_SET_A + 8'(4 * g)) begin
					r_d.prdata[GSS_GW-1:0] = r_q.gain[0][g];
				end
				if (i_paddr == GSS_OFS_SET_B + 8'(4 * g)) begin
					r_d.prdata[GSS_GW-1:0] = r_q.gain[1][g];
				end
			end
			case (i_paddr)
				GSS_OFS_CFG:    r_d.prdata[15:0] = r_q.cfg;
				GSS_OFS_WAIT1:  r_d.prdata[15:0] = r_q.wait_t[0];
				GSS_OFS_WAIT2:  r_d.prdata[15:0] = r_q.wait_t[1];
				GSS_OFS_RAMP1:  r_d.prdata[15:0] = r_q.ramp_t[0];
				GSS_OFS_RAMP2:  r_d.prdata[15:0] = r_q.ramp_t[1];
				GSS_OFS_CTRL:   r_d.prdata[15:0] = r_q.ctrl;
				GSS_OFS_STATUS: r_d.prdata[4:0] = {
					r_q.st, r_q.mf, r_q.dst, r_q.cur};
				default: begin
					// Gain words filled above, rest reads zero
				end
			endcase
		end

		// Model-following pair tracks the select only when allowed
		// Never ramped: a step in this pair is only safe at standstill
		if (mf_ok) begin
			r_d.mf = i_gain_select;
		end

		// Switch sequencer
		case (r_q.st)
			GSS_ST_IDLE: begin
				r_d.cnt = '0;
				r_d.dst = r_q.cur;
				if (want != r_q.cur) begin
					if (is_auto && i_pos_mode) begin
						// Timed move: wait first, then ramp
						r_d.dst = want;
						r_d.st  = GSS_ST_WAIT;
					end else begin
						// Manual or fixed: set at once, model-following pair excepted
						r_d.cur = want;
						r_d.dst = want;
					end
				end
			end
			GSS_ST_WAIT: begin
				if (!is_auto || !i_pos_mode || want != r_q.dst) begin
					// Trigger gone: stay on present set
					r_d.st  = GSS_ST_IDLE;
					r_d.dst = r_q.cur;
					r_d.cnt = '0;
				end else if (r_q.cnt >= r_q.wait_t[r_q.dst ? 0 : 1]) begin
					// Gains untouched until wait elapses
					r_d.st  = GSS_ST_RAMP;
					r_d.cnt = '0;
				end else if (tick) begin
					r_d.cnt = r_q.cnt + 16'h0001;
				end
			end
			GSS_ST_RAMP: begin
				// Ramp always runs to its end once begun
				// A reversal is seen afresh from idle after the ramp ends
				if (r_q.cnt >= span) begin
					r_d.st  = GSS_ST_IDLE;
					r_d.cur = r_q.dst;
					r_d.cnt = '0;
				end else if (tick) begin
					r_d.cnt = r_q.cnt + 16'h0001;
				end
			end
			default: begin
				r_d.st  = GSS_ST_IDLE;
				r_d.cnt = '0;
			end
		endcase

		// Output values: blended while ramping, else current set; model-following pair always from its own set
		for (int g = 0; g < GSS_NUM_GAINS; g++) begin
			if (r_q.st == GSS_ST_RAMP) begin
				r_d.out[g] = blend[g];
			end else begin
				r_d.out[g] = r_q.gain[r_q.cur][g];
			end
		end
		r_d.out[GSS_G_MFGAIN] = r_q.gain[r_q.mf][GSS_G_MFGAIN];
		r_d.out[GSS_G_MFCOMP] = r_q.gain[r_q.mf][GSS_G_MFCOMP];
	end

	// State register with synchronous reset
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			r_q          <= '0;
			r_q.gain[0]  <= GSS_RST_GAINS;
			r_q.gain[1]  <= GSS_RST_GAINS;
			r_q.out      <= GSS_RST_GAINS;
			r_q.cfg      <= GSS_RST_CFG;
			r_q.wait_t   <= {GSS_RST_TIME, GSS_RST_TIME};
			r_q.ramp_t   <= {GSS_RST_TIME, GSS_RST_TIME};
			r_q.ctrl     <= GSS_RST_CTRL;
			r_q.st       <= GSS_ST_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	// Zero-wait slave: every access completes in one access cycle
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel && i_penable && !hit;
	assign o_prdata  = r_q.prdata;

	// Gain and status outputs
	assign o_speed_gain        = r_q.out[GSS_G_SPEED];
	assign o_speed_integral    = r_q.out[GSS_G_INTEG];
	assign o_position_gain     = r_q.out[GSS_G_POS];
	assign o_torque_filter     = r_q.out[GSS_G_TRQF];
	assign o_model_follow_gain = r_q.out[GSS_G_MFGAIN];
	assign o_model_follow_comp = r_q.out[GSS_G_MFCOMP];
	assign o_friction_gain     = r_q.out[GSS_G_FRIC];
	assign o_active_set        = r_q.cur;
	assign o_switching         = (r_q.st != GSS_ST_IDLE);
	assign o_control_structure_select = r_q.ctrl;

endmodule

`default_nettype wire

// [tb/gss_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

// Host controller: select input and drive status lines
module gss_host_model (
	// Clock, reset and bench request
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic [7:0] i_req,
	// Lines into the switcher
	output logic            o_gain_select,
	output logic            o_pos_mode,
	output logic            o_cmd_busy,
	output logic            o_motor_stopped,
	output logic            o_positioning_complete_flag,
	output logic            o_near,
	output logic            o_filt,
	output logic            o_pulse
);
	logic [7:0] lines_q; // Registered like a real controller output

	// Lines change only just after an edge
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			lines_q <= 8'h08; // Motor at rest
		end else begin
			lines_q <= i_req;
		end
	end
	assign {o_pulse, o_filt, o_near, o_positioning_complete_flag} = lines_q[7:4];
	assign {o_motor_stopped, o_cmd_busy, o_pos_mode, o_gain_select} =
		lines_q[3:0];
endmodule

`default_nettype wire

// [tb/gss_switcher_props.sv]
`timescale 1ns/100ps
`default_nettype none

// Port-level checker for the gain set switcher
module gss_switcher_props
	import gss_pkg::*;
(
	// Clock and reset
	input wire logic              i_mclk,
	input wire logic              i_rst,
	// APB
	input wire logic              i_psel,
	input wire logic              i_penable,
	input wire logic              i_pwrite,
	input wire logic [7:0]        i_paddr,
	input wire logic [GSS_DW-1:0] i_pwdata,
	input wire logic              o_pslverr,
	input wire logic [GSS_DW-1:0] o_prdata,
	// Drive status
	input wire logic              i_gain_select,
	input wire logic              i_pos_mode,
	input wire logic              i_cmd_busy,
	input wire logic              i_motor_stopped,
	// Results
	input wire logic [GSS_GW-1:0] o_position_gain,
	input wire logic [GSS_GW-1:0] o_model_follow_gain,
	input wire logic [GSS_GW-1:0] o_model_follow_comp,
	input wire logic              o_active_set,
	input wire logic              o_switching
);
	logic        wr;    // Write completing this edge
	logic [15:0] cfg_q; // Shadow of the switching config
	logic        man;   // Manual method (reserved one acts manual)
	logic        fix;   // Set held outside position control
	assign wr  = i_psel & i_penable & i_pwrite;
	assign man = cfg_q[3:0] != GSS_METH_AUTO;
	assign fix = (cfg_q[7:4] < 4'h6) ? cfg_q[4] : 1'b0;

	// Shadow follows completed writes only
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cfg_q <= 16'h0000;
		end else if (wr && i_paddr == GSS_OFS_CFG) begin
			cfg_q <= i_pwdata[15:0];
		end
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	manual_select_a: assert property (man |=>
		o_active_set == $past(i_gain_select)) else $error("manual set wrong");
	manual_idle_a: assert property (man && !o_switching |=>
		!o_switching) else $error("switching in manual");
	gain_steady_a: assert property (!wr ##1 (!wr && !o_switching)
		##1 (!o_switching && $stable(o_active_set)) |=>
		$stable(o_position_gain)) else $error("gain moved while settled");
	// Set is chosen from the config seen one edge before it shows
	fixed_set_a: assert property ((!man && !i_pos_mode
		&& !o_switching)[*2] |=> o_active_set == $past(fix))
		else $error("fixed set wrong");
	mf_auto_hold_a: assert property ((!man && !wr)[*3] |=>
		$stable(o_model_follow_gain)) else $error("mf gain moved in auto");
	mf_busy_hold_a: assert property ((man && !wr &&
		(i_cmd_busy || !i_motor_stopped))[*3] |=>
		$stable(o_model_follow_comp)) else $error("mf comp moved busy");
	cfg_readback_a: assert property (i_psel && i_penable && !i_pwrite
		&& i_paddr == GSS_OFS_CFG |-> o_prdata == {16'h0000, cfg_q})
		else $error("config readback wrong");
	misalign_err_a: assert property (i_psel && i_penable &&
		i_paddr[1:0] != 2'b00 |-> o_pslverr) else $error("no slave error");

	// Main scenarios reached
	cover property (o_switching ##1 !o_switching);
	cover property (man ##1 $changed(o_active_set));
	cover property (!man && i_pos_mode && $rose(o_active_set));
endmodule

`default_nettype wire

// [tb/gss_switcher_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module gss_switcher_tb
	import gss_pkg::*;
;
	logic        i_mclk, i_rst, i_psel, i_penable, i_pwrite;
	logic [7:0]  i_paddr, req;
	logic [31:0] i_pwdata, o_prdata;
	logic        o_pready, o_pslverr, o_active_set, o_switching;
	logic        sel, pos, busy, stop, positioning_complete_flag, near, filt, puls;
	logic [15:0] o_sg, o_si, o_pg, o_tf, o_mg, o_mc, o_fg, o_cs;
	logic [15:0] outs [7];
	logic [15:0] rstv [7] = '{16'h0190, 16'h07d0, 16'h0190, 16'h0064,
		16'h01f4, 16'h03e8, 16'h0064};
	int          fail_count, tests_run, mid, n;
	logic        exp_set; // Expected set in the condition sweep

	assign outs = '{o_sg, o_si, o_pg, o_tf, o_mg, o_mc, o_fg};
	initial i_mclk = 1'b0;
	always #5 i_mclk = ~i_mclk;

	gss_switcher #(.TICK_CYCLES(10)) u_dut (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
		.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_gain_select(sel),
		.i_pos_mode(pos), .i_cmd_busy(busy), .i_motor_stopped(stop),
		.i_positioning_complete_flag(positioning_complete_flag), .i_near_flag(near),
		.i_ref_filter_busy(filt), .i_ref_pulse(puls), .o_speed_gain(o_sg),
		.o_speed_integral(o_si), .o_position_gain(o_pg),
		.o_torque_filter(o_tf), .o_model_follow_gain(o_mg),
		.o_model_follow_comp(o_mc), .o_friction_gain(o_fg),
		.o_active_set(o_active_set), .o_switching(o_switching),
		.o_control_structure_select(o_cs));
	gss_host_model u_host (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req),
		.o_gain_select(sel), .o_pos_mode(pos), .o_cmd_busy(busy),
		.o_motor_stopped(stop), .o_positioning_complete_flag(positioning_complete_flag), .o_near(near),
		.o_filt(filt), .o_pulse(puls));

	task automatic complete_run();
		$display("fail_count %0d tests_run %0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		k = 0;
		@(posedge i_mclk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_mclk);
			k++;
		end while (o_pready !== 1'b1 && k < 50);
		r = o_prdata;
		e = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (o_pready !== 1'b1) begin
			fail_count++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, {16'h0000, d}, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, x);
		check(32'(e), 32'(xe));
	endtask

	function automatic logic [15:0] eg(input logic s, input int i);
		return (s ? 16'h2100 : 16'h0100) + 16'(i);
	endfunction

	// Outputs against set s, model-following pair against set m
	task automatic chk_outs(input logic s, input logic m);
		logic pick;
		for (int i = 0; i < 7; i++) begin
			pick = (i == 4 || i == 5) ? m : s;
			check(outs[i], eg(pick, i));
		end
	endtask

	// Bounded wait for the settled set, counting mid-ramp values
	task automatic wait_set(input logic v);
		while (o_active_set !== v && n < 2000) begin
			@(negedge i_mclk);
			n++;
			if (o_switching && o_pg > 16'h0102 && o_pg < 16'h2102) mid++;
		end
		if (n >= 2000) begin
			fail_count++;
			complete_run();
		end
	endtask

	initial begin
		{i_rst, i_psel, i_penable, i_pwrite} = 4'b1000;
		{i_paddr, i_pwdata, req} = '0;
		{fail_count, tests_run, mid, n} = '0;
		repeat (10) @(posedge i_mclk);
		i_rst <= 1'b0;
		req <= 8'h08;
		for (int i = 0; i < 7; i++) begin
			rd(8'(4 * i), {16'h0000, rstv[i]}, 1'b0);
			rd(8'(64 + 4 * i), {16'h0000, rstv[i]}, 1'b0);
			wr(8'(4 * i), eg(1'b0, i));
			wr(8'(64 + 4 * i), eg(1'b1, i));
		end
		rd(8'h9c, 32'h0, 1'b1);
		rd(8'h02, 32'h0, 1'b1);
		// Manual: select on, then off while a command runs
		req <= 8'h09;
		repeat (4) @(negedge i_mclk);
		chk_outs(1'b1, 1'b1);
		@(posedge i_mclk);
		req <= 8'h0c;
		repeat (4) @(negedge i_mclk);
		chk_outs(1'b0, 1'b1);
		@(posedge i_mclk);
		req <= 8'h08;
		repeat (4) @(negedge i_mclk);
		chk_outs(1'b0, 1'b0);
		// Automatic, condition on positioning complete
		wr(GSS_OFS_WAIT1, 16'h0003);
		wr(GSS_OFS_RAMP1, 16'h0004);
		wr(GSS_OFS_WAIT2, 16'h0002);
		wr(GSS_OFS_RAMP2, 16'h0002);
		wr(GSS_OFS_CFG, 16'h0002);
		rd(GSS_OFS_CFG, 32'h2, 1'b0);
		req <= 8'h0b;
		repeat (6) @(negedge i_mclk);
		req <= 8'h1b;
		repeat (15) @(negedge i_mclk);
		check(32'(o_pg), 32'h0102);
		n = 15;
		wait_set(1'b1);
		check(32'(n >= 60 && n <= 86), 32'h1);
		check(32'(mid > 0), 32'h1);
		repeat (2) @(negedge i_mclk);
		chk_outs(1'b1, 1'b0);
		// Condition drops, then returns inside the wait
		req <= 8'h0b;
		repeat (8) @(negedge i_mclk);
		check(32'(o_switching), 32'h1);
		req <= 8'h1b;
		repeat (40) @(negedge i_mclk);
		check({o_active_set, o_switching, o_pg}, {2'b10, 16'h2102});
		rd(GSS_OFS_STATUS, 32'h3, 1'b0);
		// Every condition source, I-P structure, zero times
		wr(GSS_OFS_CTRL, 16'h0001);
		wr(GSS_OFS_WAIT1, 16'h0000);
		wr(GSS_OFS_RAMP1, 16'h0000);
		wr(GSS_OFS_WAIT2, 16'h0000);
		wr(GSS_OFS_RAMP2, 16'h0000);
		check(32'(o_cs), 32'h1);
		for (int c = 0; c < 6; c++) begin
			for (int v = 0; v < 2; v++) begin
				wr(GSS_OFS_CFG, 16'(c * 16 + 2));
				req <= v[0] ? 8'hfa : 8'h0a;
				repeat (10) @(negedge i_mclk);
				exp_set = (c == 4) ? !v[0] : (c == 5) ? v[0] : c[0] ^ v[0];
				check(32'(o_active_set), 32'(exp_set));
				@(posedge i_mclk);
				req <= v[0] ? 8'hf8 : 8'h08;
				repeat (4) @(negedge i_mclk);
				check(32'(o_active_set), 32'(c[0]));
			end
		end
		complete_run();
	end
endmodule

bind gss_switcher gss_switcher_props u_props (.i_mclk(i_mclk),
	.i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_pslverr(o_pslverr), .o_prdata(o_prdata),
	.i_gain_select(i_gain_select), .i_pos_mode(i_pos_mode),
	.i_cmd_busy(i_cmd_busy), .i_motor_stopped(i_motor_stopped),
	.o_position_gain(o_position_gain),
	.o_model_follow_gain(o_model_follow_gain),
	.o_model_follow_comp(o_model_follow_comp),
	.o_active_set(o_active_set), .o_switching(o_switching));

`default_nettype wire
